// ### hps_slot_defs.svh
`ifndef HPS_SLOT_DEFS_SVH
`define HPS_SLOT_DEFS_SVH

// word indices; byte address is four times the index
`define HPS_IDX_SLOT_CTL 10'h058
`define HPS_IDX_SLOT_STS 10'h05a
`define HPS_IDX_DEV_CAP2 10'h064
`define HPS_IDX_DEV_CTL2 10'h068
`define HPS_IDX_IRQ_MASK 10'h0f0

// slot event status fields
`define HPS_STS_BUTTON 0
`define HPS_STS_FAULT 1
`define HPS_STS_LATCH_CHG 2
`define HPS_STS_PRES_CHG 3
`define HPS_STS_CMD_DONE 4
`define HPS_STS_LATCH 5
`define HPS_STS_PRESENT 6
`define HPS_STS_INTERLOCK 7
`define HPS_STS_LINK_CHG 8
`define HPS_STS_W1C_MASK 16'h011f

// slot control fields
`define HPS_CTL_HP_IRQ_EN 5
`define HPS_CTL_INTERLOCK_CTL 11
`define HPS_CTL_LINK_CHG_EN 12
`define HPS_CTL_WR_MASK 16'h17ff
`define HPS_CTL_RESET 16'h01c0

// capability and control 2 fields
`define HPS_FWD_BIT 5

// reset values
`define HPS_MASK_RESET 16'h011f
`define HPS_PRESENT_RESET 1'b1
`define HPS_LATCH_RESET 1'b0

`endif

// ### hps_slot_pkg.sv
package hps_slot_pkg;

   // levels sensed from the slot through the expander
   typedef struct packed {
      logic button;
      logic power_fault;
      logic latch_open;
      logic card_present;
      logic interlock_engaged;
   } hps_slot_pins_type;

   // command handed to the expander engine
   typedef struct packed {
      logic start;
      logic [15:0] slot_ctl;
   } hps_cmd_type;

endpackage : hps_slot_pkg

// ### hps_slot_status.sv
`timescale 1ns/1ps
`default_nettype none
`include "hps_slot_defs.svh"

module hps_slot_status
   import hps_slot_pkg::*;
#(
   parameter int ADR_W = 12,
   parameter bit UPSTREAM_PORT = 1'b0,
   parameter bit FWD_SUPPORTED = 1'b1,
   parameter bit INTERLOCK_PRESENT = 1'b1,
   parameter int PEND_W = 3
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // slot sensors, asynchronous
   input wire hps_slot_pins_type slot_pins_i,
   // link layer, same clock
   input wire logic link_active_i,
   // expander command engine, same clock
   output hps_cmd_type cmd_o,
   input wire logic cmd_done_i,
   // control outputs
   output logic routing_forward_enable_o,
   output logic irq_o
);

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   if (ADR_W < 12) begin : g_adr_chk
      $error("hps_slot_status: ADR_W must be at least 12");
   end
   if (PEND_W < 1) begin : g_pend_chk
      $error("hps_slot_status: PEND_W must be at least 1");
   end

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   localparam hps_slot_pins_type PINS_RESET = '{
      button: 1'b0,
      power_fault: 1'b0,
      latch_open: `HPS_LATCH_RESET,
      card_present: `HPS_PRESENT_RESET,
      interlock_engaged: 1'b0
   };

   hps_slot_pins_type pins_meta;
   hps_slot_pins_type pins_sync;
   hps_slot_pins_type pins_prev;
   logic link_prev;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pins_meta <= PINS_RESET;
         pins_sync <= PINS_RESET;
         pins_prev <= PINS_RESET;
         link_prev <= 1'b0;
      end else begin
         pins_meta <= slot_pins_i;
         pins_sync <= pins_meta;
         pins_prev <= pins_sync;
         link_prev <= link_active_i;
      end
   end

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   wire logic bus_req;
   wire logic bus_wr;
   wire logic [9:0] word_idx;
   wire logic [31:0] lane_mask;
   wire logic [15:0] wdata;
   wire logic hit_ctl;
   wire logic hit_sts;
   wire logic hit_cap2;
   wire logic hit_ctl2;
   wire logic hit_mask;

   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign bus_wr = bus_req & wb_we_i;
   assign word_idx = wb_adr_i[11:2];
   assign lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                       {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign wdata = wb_dat_i[15:0] & lane_mask[15:0];
   assign hit_ctl = (word_idx == `HPS_IDX_SLOT_CTL);
   assign hit_sts = (word_idx == `HPS_IDX_SLOT_STS);
   assign hit_cap2 = (word_idx == `HPS_IDX_DEV_CAP2);
   assign hit_ctl2 = (word_idx == `HPS_IDX_DEV_CTL2);
   assign hit_mask = (word_idx == `HPS_IDX_IRQ_MASK);

   wire logic wr_ctl;
   wire logic wr_sts;
   wire logic wr_ctl2;
   wire logic wr_mask;

   assign wr_ctl = bus_wr & hit_ctl & (|wb_sel_i[1:0]);
   assign wr_sts = bus_wr & hit_sts;
   assign wr_ctl2 = bus_wr & hit_ctl2;
   assign wr_mask = bus_wr & hit_mask;

   // ----------------------------------------------------------------
   // events
   // ----------------------------------------------------------------
   logic [PEND_W-1:0] pend_cnt;
   wire logic cmd_busy;
   wire logic ev_cmd_done;
   wire logic [15:0] ev_set;

   assign cmd_busy = (pend_cnt != '0);
   // done only counts the last outstanding command
   assign ev_cmd_done = cmd_done_i & (pend_cnt == PEND_W'(1)) & ~wr_ctl;

   assign ev_set = {
      7'h00,
      link_active_i ^ link_prev,
      3'h0,
      ev_cmd_done,
      pins_sync.card_present ^ pins_prev.card_present,
      pins_sync.latch_open ^ pins_prev.latch_open,
      pins_sync.power_fault & ~pins_prev.power_fault,
      pins_sync.button & ~pins_prev.button
   };

   // ----------------------------------------------------------------
   // sticky flags
   // ----------------------------------------------------------------
   logic [15:0] flags;
   wire logic [15:0] clr;
   wire logic [15:0] next_flags;

   assign clr = wr_sts ? wdata : 16'h0000;
   // set wins over a clear in the same cycle
   assign next_flags = ((flags & ~clr) | ev_set) & `HPS_STS_W1C_MASK;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags <= 16'h0000;
      end else begin
         flags <= next_flags;
      end
   end

   // ----------------------------------------------------------------
   // slot control and command issue
   // ----------------------------------------------------------------
   logic [15:0] slot_ctl;
   wire logic [15:0] next_slot_ctl;
   wire logic [PEND_W-1:0] next_pend;

   assign next_slot_ctl = (slot_ctl & ~lane_mask[15:0])
                        | (wdata & `HPS_CTL_WR_MASK);
   // saturate rather than wrap if the engine falls behind
   assign next_pend = (wr_ctl && !(cmd_done_i && cmd_busy))
                      ? ((&pend_cnt) ? pend_cnt : pend_cnt + PEND_W'(1))
                      : ((!wr_ctl && cmd_done_i && cmd_busy)
                         ? pend_cnt - PEND_W'(1) : pend_cnt);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         slot_ctl <= `HPS_CTL_RESET;
         pend_cnt <= '0;
         cmd_o <= '0;
      end else begin
         pend_cnt <= next_pend;
         cmd_o.start <= wr_ctl;
         if (wr_ctl) begin
            slot_ctl <= next_slot_ctl;
            cmd_o.slot_ctl <= next_slot_ctl;
         end
      end
   end

   // ----------------------------------------------------------------
   // forwarding capability and enable
   // ----------------------------------------------------------------
   localparam bit FWD_SUP = FWD_SUPPORTED & ~UPSTREAM_PORT;
   logic fwd_en;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fwd_en <= 1'b0;
      end else if (wr_ctl2 && wb_sel_i[0]) begin
         fwd_en <= wb_dat_i[`HPS_FWD_BIT] & FWD_SUP;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         routing_forward_enable_o <= 1'b0;
      end else begin
         routing_forward_enable_o <= fwd_en;
      end
   end

   // ----------------------------------------------------------------
   // interrupt
   // ----------------------------------------------------------------
   logic [15:0] irq_mask;
   wire logic [15:0] ev_enable;
   wire logic next_irq;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask <= `HPS_MASK_RESET;
      end else if (wr_mask) begin
         irq_mask <= ((irq_mask & ~lane_mask[15:0]) | wdata) & `HPS_STS_W1C_MASK;
      end
   end

   // per-event enables sit in slot control, link enable at bit 12
   assign ev_enable = {7'h00, slot_ctl[`HPS_CTL_LINK_CHG_EN], 3'h0, slot_ctl[4:0]};
   assign next_irq = slot_ctl[`HPS_CTL_HP_IRQ_EN]
                   & (|(flags & ev_enable & irq_mask));

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= next_irq;
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   wire logic [15:0] sts_view;
   wire logic [15:0] ctl_view;
   wire logic [31:0] cap2_view;
   wire logic [31:0] rd_mux;

   assign sts_view = flags
      | (16'(pins_sync.latch_open) << `HPS_STS_LATCH)
      | (16'(pins_sync.card_present) << `HPS_STS_PRESENT)
      | (16'(pins_sync.interlock_engaged & INTERLOCK_PRESENT)
         << `HPS_STS_INTERLOCK);
   // interlock control always reads back zero
   assign ctl_view = slot_ctl & ~(16'h0001 << `HPS_CTL_INTERLOCK_CTL);
   assign cap2_view = 32'(FWD_SUP) << `HPS_FWD_BIT;

   // unmapped words and reserved bits read zero
   assign rd_mux = hit_sts ? {16'h0000, sts_view} :
                   hit_ctl ? {16'h0000, ctl_view} :
                   hit_cap2 ? cap2_view :
                   hit_ctl2 ? (32'(fwd_en & FWD_SUP) << `HPS_FWD_BIT) :
                   hit_mask ? {16'h0000, irq_mask} :
                   32'h0000_0000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_req && !wb_we_i) begin
            wb_dat_o <= rd_mux;
         end
      end
   end

endmodule : hps_slot_status
`default_nettype wire

// ### hps_slot_status_sva.sv
`timescale 1ns/1ps
`default_nettype none
module hps_slot_status_sva
   import hps_slot_pkg::*;
#(
   parameter int ADR_W = 12,
   parameter bit UPSTREAM_PORT = 1'b0,
   parameter bit FWD_SUPPORTED = 1'b1
) (
   // watched ports
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire hps_cmd_type cmd_o,
   input wire logic routing_forward_enable_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   wire logic take = wb_cyc_i & wb_stb_i & !wb_ack_o;
   wire logic rd = wb_ack_o & !wb_we_i;
   wire logic [9:0] idx = wb_adr_i[11:2];
   sequence s_ctl_wr;
      take && wb_we_i && idx == 10'h058 && (|wb_sel_i[1:0]);
   endsequence
   a_ack_pulse: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not one cycle");
   a_no_stray_ack: assert property (!take |=> !wb_ack_o)
      else $error("stray ack");
   a_one_cmd: assert property (s_ctl_wr |=> cmd_o.start ##1 !cmd_o.start)
      else $error("no single start");
   a_cmd_cause: assert property (cmd_o.start |-> $past(take && wb_we_i))
      else $error("start without write");
   a_sts_reserved: assert property (rd && idx == 10'h05a |-> wb_dat_o[31:9] == 23'h0)
      else $error("status reserved set");
   a_cap_value: assert property (rd && idx == 10'h064 |->
      wb_dat_o == {26'h0, FWD_SUPPORTED && !UPSTREAM_PORT, 5'h0})
      else $error("capability wrong");
   a_fwd_gated: assert property (routing_forward_enable_o |-> FWD_SUPPORTED && !UPSTREAM_PORT)
      else $error("forwarding unsupported");
   a_dctl_reserved: assert property (rd && idx == 10'h068 |-> wb_dat_o[4:0] == 5'h0)
      else $error("control 2 reserved set");
endmodule : hps_slot_status_sva
bind hps_slot_status hps_slot_status_sva #(.ADR_W(ADR_W), .UPSTREAM_PORT(UPSTREAM_PORT),
   .FWD_SUPPORTED(FWD_SUPPORTED)) i_hps_slot_status_sva (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmd_o(cmd_o),
   .routing_forward_enable_o(routing_forward_enable_o));
`default_nettype wire

// ### hps_slot_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// expander engine: serial, one done per start
// ----
module hps_slot_partner
   import hps_slot_pkg::*;
(
   // clock, command in, done out
   input wire logic clk_i,
   input wire logic rst_i,
   input wire hps_cmd_type cmd_i,
   input wire logic slow_i,
   output logic cmd_done_o
);
   int pend;
   int cnt;
   logic done;
   // one non-blocking drive of done per edge
   always @(posedge clk_i) begin
      done = 1'b0;
      pend = rst_i ? 0 : pend + cmd_i.start;
      if (rst_i || cnt > 1) begin
         cnt = rst_i ? 0 : cnt - 1;
      end else if (cnt == 1) begin
         cnt = 0;
         pend = pend - 1;
         done = 1'b1;
      end else if (pend > 0) begin
         cnt = slow_i ? 30 : 2;
      end
      cmd_done_o <= done;
   end
endmodule : hps_slot_partner
`default_nettype wire

// ### hps_slot_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) \
   begin \
      checks++; \
      if ((a) !== (e)) begin \
         errors++; \
         $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); \
      end \
   end
module hps_slot_status_tb import hps_slot_pkg::*;;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [11:0] wb_adr_i = 12'h000;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   hps_slot_pins_type slot_pins_i = 5'b00010;
   logic link_active_i = 1'b0;
   hps_cmd_type cmd_o;
   logic cmd_done_i;
   logic slow = 1'b0;
   logic fwd;
   logic irq_o;
   logic [31:0] rd;
   int errors = 0;
   int checks = 0;
   int starts = 0;
   int dones = 0;
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   hps_slot_status i_hps_slot_status (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .slot_pins_i, .link_active_i,
      .cmd_o, .cmd_done_i, .routing_forward_enable_o(fwd), .irq_o);
   hps_slot_partner i_hps_slot_partner (.clk_i, .rst_i, .cmd_i(cmd_o), .slow_i(slow),
      .cmd_done_o(cmd_done_i));
   always @(posedge clk_i) begin
      starts += (cmd_o.start === 1'b1);
      dones += (cmd_done_i === 1'b1);
   end
   task automatic bus(input logic we, input logic [11:0] adr, input logic [31:0] dat);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : bus
   task automatic chk_rd(input logic [11:0] adr, input logic [31:0] exp);
      bus(1'b0, adr, 32'h0);
      `CHK(rd, exp)
   endtask : chk_rd
   task automatic wait_done();
      int n;
      n = 0;
      while (dones != starts && n < 200) begin
         @(posedge clk_i);
         n++;
      end
      repeat (2) @(posedge clk_i);
   endtask : wait_done
   task automatic stop_test();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk_rd(12'h168, 32'h40);
      chk_rd(12'h190, 32'h20);
      chk_rd(12'h004, 32'h0);
      $display("reset test done");
      slot_pins_i <= 5'b11111;
      repeat (5) @(posedge clk_i);
      chk_rd(12'h168, 32'he7);
      slot_pins_i <= 5'b11101;
      link_active_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      chk_rd(12'h168, 32'h1af);
      bus(1'b1, 12'h168, 32'h5);
      chk_rd(12'h168, 32'h1aa);
      bus(1'b1, 12'h168, 32'h0);
      chk_rd(12'h168, 32'h1aa);
      bus(1'b1, 12'h168, 32'h11f);
      chk_rd(12'h168, 32'ha0);
      $display("event test done");
      slow <= 1'b1;
      bus(1'b1, 12'h160, 32'h3f);
      chk_rd(12'h168, 32'ha0);
      wait_done();
      chk_rd(12'h168, 32'hb0);
      `CHK(irq_o, 1'b1)
      bus(1'b1, 12'h3c0, 32'h0);
      `CHK(irq_o, 1'b0)
      bus(1'b1, 12'h3c0, 32'h11f);
      `CHK(irq_o, 1'b1)
      bus(1'b1, 12'h168, 32'h10);
      `CHK(irq_o, 1'b0)
      slow <= 1'b0;
      bus(1'b1, 12'h160, 32'h1f);
      bus(1'b1, 12'h160, 32'h3f);
      wait_done();
      chk_rd(12'h168, 32'hb0);
      `CHK(starts, 3)
      `CHK(cmd_o.slot_ctl, 16'h003f)
      chk_rd(12'h160, 32'h3f);
      $display("command test done");
      bus(1'b1, 12'h1a0, 32'h20);
      chk_rd(12'h1a0, 32'h20);
      `CHK(fwd, 1'b1)
      $display("forwarding test done");
      stop_test();
   end
   // generous: the whole sequence needs some 120 cycles
   initial begin
      repeat (3000) @(posedge clk_i);
      errors++;
      stop_test();
   end
endmodule : hps_slot_status_tb
`default_nettype wire
